// File: testbench/ast_host.sv
// Purpose: Host-side model of the serial clock pin and the result line.
// Assumes: The host drives the clock pin only while host_oe is high.
// Notes: A released clock pin without pull-up keeps its level, as a loaded pin does.
`timescale 1ns/10ps
`default_nettype none

module ast_host (
    input  wire logic dev_oe,
    input  wire logic dev_out,
    input  wire logic pullup_en,
    input  wire logic host_oe,
    input  wire logic host_out,
    input  wire logic sdo_oe,
    input  wire logic sdo_out,
    output logic      sck_pin,
    output logic      sdo_line
);
    // The pin is only pulled high while the device enables its weak pull-up.
    always @(dev_oe, dev_out, pullup_en, host_oe, host_out)
    begin
        if (dev_oe)
            sck_pin = dev_out;
        else if (host_oe)
            sck_pin = host_out;
        else if (pullup_en)
            sck_pin = 1'b1;
    end

    // A floating line shows the inverse so a stale value never passes.
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_out;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the serial timing modes.
// Assumes: Shortened conversion and test window through parameters.
// Notes: The external serial clock has a 12 ns period and runs only in frames.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int CFG = 8;
    logic        clock;
    logic        reset_n;
    logic        chip_select_n;
    logic        serial_config_in;
    logic        host_oe;
    logic        host_out;
    logic [22:0] adc_result;
    logic        sck_pin;
    logic        sdo_line;
    logic        sck_out;
    logic        sck_oe;
    logic        pullup_en;
    logic        sdo_out;
    logic        sdo_oe;
    logic [7:0]  config_word;
    logic        config_update;
    logic        converting;
    logic        ext_clock_mode;
    logic [23:0] w;
    int          num_errors = 0;
    int          checks = 0;
    int          cfg_pulses = 0;

    ast_top #(.CONV_CYCLES(50), .OSC_PERIOD_NS(100), .HALF_SCK(4), .CFG_BITS(CFG)) i_dut (
        .clock                  (clock),
        .reset_n                (reset_n),
        .chip_select_n          (chip_select_n),
        .serial_clock_in        (sck_pin),
        .serial_clock_out       (sck_out),
        .serial_clock_oe        (sck_oe),
        .serial_clock_pullup_en (pullup_en),
        .serial_config_in       (serial_config_in),
        .serial_result_out      (sdo_out),
        .serial_result_oe       (sdo_oe),
        .adc_result             (adc_result),
        .config_word            (config_word),
        .config_update          (config_update),
        .converting             (converting),
        .ext_clock_mode         (ext_clock_mode)
    );

    ast_host i_host (
        .dev_oe    (sck_oe),
        .dev_out   (sck_out),
        .pullup_en (pullup_en),
        .host_oe   (host_oe),
        .host_out  (host_out),
        .sdo_oe    (sdo_oe),
        .sdo_out   (sdo_out),
        .sck_pin   (sck_pin),
        .sdo_line  (sdo_line)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Counts configuration update pulses; each must appear exactly once.
    always @(posedge clock)
    begin
        if (config_update === 1'b1)
            cfg_pulses++;
    end

    task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
            num_errors++;
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        check_val({23'h0, got}, {23'h0, exp}, what);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wait_sleep;
        int n;
        n = 0;
        while (converting !== 1'b0 && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        check_flag(converting, 1'b0, "sleep");
    endtask

    // The host keeps the clock low at every select fall to stay external.
    task automatic ext_frame(input int n, input logic [7:0] cfg, output logic [23:0] word);
        chip_select_n <= 1'b0;
        wait_clk(4);
        for (int k = 1; k <= n; k++)
        begin
            serial_config_in = (k <= CFG) ? cfg[CFG-k] : 1'b0;
            #6 host_out = 1'b1;
            if (k <= 24)
                word[24-k] = sdo_line;
            else
                check_flag(sdo_line, 1'b1, "extra clock");
            #6 host_out = 1'b0;
        end
        wait_clk(1);
    endtask

    task automatic t_reset;
        wait_clk(6);
        check_flag(ext_clock_mode, 1'b1, "strap");
        check_flag(converting, 1'b1, "first conversion");
        check_val({16'h0, config_word}, 24'h0, "config reset");
    endtask

    task automatic t_poll;
        chip_select_n <= 1'b0;
        wait_clk(4);
        check_flag(sdo_oe, 1'b1, "poll drive");
        check_flag(sdo_line, 1'b1, "busy status");
        chip_select_n <= 1'b1;
        wait_clk(2);
        check_flag(sdo_oe, 1'b0, "float");
        wait_sleep();
        chip_select_n <= 1'b0;
        wait_clk(4);
        check_flag(sdo_line, 1'b0, "done status");
        chip_select_n <= 1'b1;
        wait_clk(4);
    endtask

    task automatic t_ext_read;
        wait_sleep();
        ext_frame(32, 8'ha5, w);
        check_val(w, {1'b0, adc_result}, "word");
        check_flag(sdo_line, 1'b1, "busy after word");
        wait_clk(5);
        check_flag(converting, 1'b1, "new conversion");
        check_val({16'h0, config_word}, 24'ha5, "config");
        check_val(24'(cfg_pulses), 24'h1, "config pulse");
        chip_select_n <= 1'b1;
        wait_clk(4);
    endtask

    task automatic t_abort;
        wait_sleep();
        ext_frame(5, 8'h3c, w);
        chip_select_n <= 1'b1;
        wait_clk(5);
        check_flag(converting, 1'b1, "abort converts");
        check_val({19'h0, w[23:19]}, {19'h0, 1'b0, adc_result[22:19]}, "partial");
        check_val({16'h0, config_word}, 24'ha5, "config kept");
        check_val(24'(cfg_pulses), 24'h1, "no config pulse");
    endtask

    task automatic t_internal;
        int n;
        wait_sleep();
        host_out <= 1'b1;
        wait_clk(4);
        host_oe <= 1'b0;
        wait_clk(4);
        check_flag(pullup_en, 1'b1, "pull-up on");
        chip_select_n <= 1'b0;
        n = 0;
        while (sck_pin !== 1'b0 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        check_flag(sck_oe, 1'b1, "device drives clock");
        n = 0;
        while (sck_pin !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        check_flag(n >= 14 && n <= 17, 1'b1, "test window");
        word_loop(w);
        check_val(w, {1'b0, adc_result}, "internal word");
        wait_clk(6);
        check_flag(converting, 1'b1, "internal converts");
        check_flag(sck_pin, 1'b1, "clock held high");
        check_flag(ext_clock_mode, 1'b0, "internal mode");
        chip_select_n <= 1'b1;
        wait_clk(4);
    endtask

    task automatic word_loop(output logic [23:0] word);
        word[23] = sdo_line;
        for (int k = 2; k <= 24; k++)
        begin
            @(posedge sck_pin);
            word[24-k] = sdo_line;
        end
    endtask

    task automatic t_int_poll;
        wait_sleep();
        chip_select_n <= 1'b0;
        wait_clk(7);
        check_flag(sck_pin, 1'b0, "clock pulled low");
        check_flag(pullup_en, 1'b0, "pull-up off");
        chip_select_n <= 1'b1;
        wait_clk(6);
        check_flag(pullup_en, 1'b1, "pull-up back");
        wait_clk(30);
        check_flag(converting, 1'b0, "stays asleep");
    endtask

    // Select rises one system clock after the second internal rise.
    task automatic t_int_abort;
        chip_select_n <= 1'b0;
        repeat (2) @(posedge sck_pin);
        wait_clk(1);
        chip_select_n <= 1'b1;
        wait_clk(6);
        check_flag(converting, 1'b1, "internal abort converts");
        check_flag(sck_pin, 1'b1, "clock high after abort");
    endtask

    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        conclude();
    end

    initial
    begin
        reset_n = 1'b0;
        chip_select_n = 1'b1;
        serial_config_in = 1'b0;
        host_oe = 1'b1;
        host_out = 1'b0;
        adc_result = 23'h5a3c69;
        wait_clk(6);
        reset_n <= 1'b1;
        t_reset();
        t_poll();
        t_ext_read();
        t_abort();
        t_internal();
        t_int_poll();
        t_int_abort();
        conclude();
    end
endmodule
`default_nettype wire

// File: verilog/ast_link.sv
// Purpose: Shift engine running on the serial clock pin.
// Assumes: Word is stable whenever link_rst_n is high.
// Notes: Events leave this domain as toggles that only reset_n clears.
`timescale 1ns/10ps
`default_nettype none

module ast_link #(
    parameter int CFG_BITS = ast_pkg::DEF_CFG_BITS
) (
    input  wire logic                          sck,
    input  wire logic                          reset_n,
    input  wire logic                          link_rst_n,
    input  wire logic                          config_in,
    input  wire logic [ast_pkg::WORD_BITS-1:0] word,
    output logic                               out_bit,
    output logic                               rise_tgl,
    output logic                               done_tgl,
    output logic                               cfg_tgl,
    output logic      [CFG_BITS-1:0]           cfg_word
);

    localparam logic [4:0] CFG_LAST = 5'(CFG_BITS - 1);

    logic [4:0]          rcnt;
    logic [4:0]          fcnt;
    logic [CFG_BITS-1:0] cfg_shift;

    wire rise_live = (rcnt != ast_pkg::BITS_ALL);
    // A fall before the first rise is the status-window low of the
    // internal clock; shifting on it would drop the status bit.
    wire fall_live = (fcnt != ast_pkg::BITS_ALL) & (rcnt != 5'h0);
    wire cfg_last  = (rcnt == CFG_LAST);
    wire fall_last = (fcnt == ast_pkg::BITS_LAST);
    wire [CFG_BITS-1:0] cfg_next = {cfg_shift[CFG_BITS-2:0], config_in};

    // Counters clear whenever select is high or a conversion runs,
    // so clocks beyond the 24th are ignored until the next sleep.
    always_ff @(posedge sck or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rcnt      <= '0;
            cfg_shift <= '0;
        end
        else if (rise_live)
        begin
            rcnt      <= rcnt + 5'h1;
            cfg_shift <= cfg_next;
        end
    end

    // A partial configuration is never copied out.
    always_ff @(posedge sck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rise_tgl <= 1'b0;
            cfg_tgl  <= 1'b0;
            cfg_word <= '0;
        end
        else if (link_rst_n)
        begin
            if (rcnt == 5'h0)
                rise_tgl <= ~rise_tgl;
            if (cfg_last)
            begin
                cfg_word <= cfg_next;
                cfg_tgl  <= ~cfg_tgl;
            end
        end
    end

    // Bit 23 is the status bit, zero while asleep, shown before any fall.
    always_ff @(negedge sck or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            fcnt    <= '0;
            out_bit <= 1'b0;
        end
        else if (fall_live)
        begin
            fcnt    <= fcnt + 5'h1;
            out_bit <= fall_last ? 1'b1 : word[ast_pkg::IDX_TOP - fcnt];
        end
    end

    always_ff @(negedge sck or negedge reset_n)
    begin
        if (!reset_n)
            done_tgl <= 1'b0;
        else if (link_rst_n && fall_last)
            done_tgl <= ~done_tgl;
    end

    a_tail_ones: assert property (@(negedge sck) disable iff (!link_rst_n)
        (fcnt == ast_pkg::BITS_LAST) |=> out_bit ##1 out_bit)
        else $error("output not high after last bit");

    a_cfg_capture: assert property (@(posedge sck) disable iff (!link_rst_n)
        cfg_last |=> (cfg_word == $past(cfg_next)))
        else $error("configuration word not captured");

endmodule

`default_nettype wire

// File: verilog/ast_pkg.sv
// Purpose: Shared constants and types for the converter serial timing block.
// Assumes: System clock of 40 MHz; serial clock arrives on its own pin.
// Notes: Timing defaults, word layout and state encoding follow.

package ast_pkg;

    localparam int CLK_PERIOD_NS      = 25;
    localparam int WORD_BITS          = 24;
    localparam int TEST_OSC_X10       = 36;
    localparam int DEF_OSC_PERIOD_NS  = 1000;
    localparam int DEF_CONV_CYCLES    = 4000;
    localparam int DEF_HALF_SCK       = 4;
    localparam int DEF_CFG_BITS       = 8;
    localparam logic [1:0] POR_STRAP  = 2'h2;
    localparam logic [1:0] POR_DONE   = 2'h3;
    localparam logic [4:0] BITS_LAST  = 5'h17;
    localparam logic [4:0] BITS_ALL   = 5'h18;
    localparam logic [4:0] IDX_TOP    = 5'h16;

    typedef enum logic [1:0]
    {
        ST_CONVERT = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_TEST    = 2'b10,
        ST_DATA    = 2'b11
    } ast_state_t;

endpackage

// File: verilog/ast_sync.sv
// Purpose: Two-stage synchroniser for levels and toggles.
// Assumes: Inputs are asynchronous to clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none

module ast_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// File: verilog/ast_top.sv
// Purpose: Conversion cycle and serial timing modes of the converter.
// Assumes: The analog core offers a settled result at conversion end.
// Notes: Shifting runs on the serial clock pin; this file keeps states.
`timescale 1ns/10ps
`default_nettype none

module ast_top #(
    parameter int CONV_CYCLES   = ast_pkg::DEF_CONV_CYCLES,
    parameter int OSC_PERIOD_NS = ast_pkg::DEF_OSC_PERIOD_NS,
    parameter int HALF_SCK      = ast_pkg::DEF_HALF_SCK,
    parameter int CFG_BITS      = ast_pkg::DEF_CFG_BITS
) (
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    input  wire logic                          chip_select_n,
    input  wire logic                          serial_clock_in,
    output logic                               serial_clock_out,
    output logic                               serial_clock_oe,
    output logic                               serial_clock_pullup_en,
    input  wire logic                          serial_config_in,
    output logic                               serial_result_out,
    output logic                               serial_result_oe,
    input  wire logic [ast_pkg::WORD_BITS-2:0] adc_result,
    output logic      [CFG_BITS-1:0]           config_word,
    output logic                               config_update,
    output logic                               converting,
    output logic                               ext_clock_mode
);

    // The status window is 3.6 oscillator periods, kept as least time.
    localparam int STATUS_TEST_WINDOW_NS = OSC_PERIOD_NS * ast_pkg::TEST_OSC_X10 / 10;
    localparam int TEST_RAW = (STATUS_TEST_WINDOW_NS + ast_pkg::CLK_PERIOD_NS - 1)
                            / ast_pkg::CLK_PERIOD_NS;
    localparam int TEST_CYCLES = (TEST_RAW < 1) ? 1 : TEST_RAW;
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int TW = $clog2(TEST_CYCLES + 1);
    localparam int HW = $clog2(HALF_SCK + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam logic [TW-1:0] TEST_LAST = TW'(TEST_CYCLES - 1);
    localparam logic [HW-1:0] HALF_LAST = HW'(HALF_SCK - 1);

    ast_pkg::ast_state_t state;
    ast_pkg::ast_state_t next_state;

    logic [CW-1:0]  conv_cnt;
    logic [TW-1:0]  test_cnt;
    logic [HW-1:0]  half_cnt;
    logic [4:0]     rise_cnt;
    logic           sck_level;
    logic           cs_q;
    logic [1:0]     por_cnt;
    logic           pullup_force;
    logic [2:0]     tgl_q;
    logic [ast_pkg::WORD_BITS-1:0] result_word;

    logic [4:0]          sync_out;
    logic                rise_tgl;
    logic                done_tgl;
    logic                cfg_tgl;
    logic                link_bit;
    logic [CFG_BITS-1:0] link_cfg;

    // Select and clock pin levels plus the three link toggles.
    ast_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h01)
    ) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in ({cfg_tgl, done_tgl, rise_tgl, serial_clock_in, chip_select_n}),
        .sync_out (sync_out)
    );

    wire cs_s      = sync_out[0];
    wire sck_s     = sync_out[1];
    wire [2:0] tgl = sync_out[4:2];
    wire cs_fall   = cs_q & ~cs_s;
    wire cs_rise   = ~cs_q & cs_s;
    wire rise_evt  = tgl[0] ^ tgl_q[0];
    wire done_evt  = tgl[1] ^ tgl_q[1];
    wire cfg_evt   = tgl[2] ^ tgl_q[2];

    // Mode is picked from the synchronised clock level at the select
    // fall; both pins pass equal stages so the sample lines up.
    wire strap_now      = (por_cnt == ast_pkg::POR_STRAP);
    wire next_ext_mode  = (strap_now | cs_fall) ? ~sck_s : ext_clock_mode;

    wire in_convert = (state == ast_pkg::ST_CONVERT);
    wire in_sleep   = (state == ast_pkg::ST_SLEEP);
    wire in_test    = (state == ast_pkg::ST_TEST);
    wire in_data    = (state == ast_pkg::ST_DATA);

    wire conv_end  = in_convert & (conv_cnt == CONV_LAST);
    wire test_end  = in_test & (test_cnt == TEST_LAST);
    wire half_end  = (half_cnt == HALF_LAST);
    wire int_rise  = in_data & ~ext_clock_mode & half_end & ~sck_level;
    wire int_last  = int_rise & (rise_cnt == ast_pkg::BITS_LAST);

    // Internal clock with select low goes straight to the status window.
    wire conv_to_test = ~next_ext_mode & ~cs_s;
    wire sleep_wake   = next_ext_mode ? rise_evt : cs_fall;
    wire data_done    = ext_clock_mode ? done_evt : int_last;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ast_pkg::ST_CONVERT:
                if (conv_end)
                    next_state = conv_to_test ? ast_pkg::ST_TEST : ast_pkg::ST_SLEEP;
            ast_pkg::ST_SLEEP:
                if (sleep_wake)
                    next_state = next_ext_mode ? ast_pkg::ST_DATA : ast_pkg::ST_TEST;
            ast_pkg::ST_TEST:
                if (cs_rise)
                    next_state = ast_pkg::ST_SLEEP;
                else if (test_end)
                    next_state = ast_pkg::ST_DATA;
            ast_pkg::ST_DATA:
                if (cs_rise | data_done)
                    next_state = ast_pkg::ST_CONVERT;
        endcase
    end

    wire enter_data = in_test & (next_state == ast_pkg::ST_DATA);
    wire next_level = in_convert | enter_data | (next_state == ast_pkg::ST_CONVERT) ? 1'b1 :
                      in_test ? 1'b0 :
                      (in_data & half_end) ? ~sck_level : sck_level;
    wire [4:0] next_rise = enter_data ? 5'h1 :
                           int_rise ? rise_cnt + 5'h1 :
                           in_data ? rise_cnt : 5'h0;

    // A poll that found the part asleep pulled the clock low; the
    // pull-up returns when select rises inside the window.
    wire next_force = (in_test & cs_rise) | (pullup_force & ~sck_s);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ast_pkg::ST_CONVERT;
            cs_q  <= 1'b1;
            tgl_q <= 3'h0;
        end
        else
        begin
            state <= next_state;
            cs_q  <= cs_s;
            tgl_q <= tgl;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            por_cnt <= 2'h0;
        else if (por_cnt != ast_pkg::POR_DONE)
            por_cnt <= por_cnt + 2'h1;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ext_clock_mode <= 1'b0;
        else
            ext_clock_mode <= next_ext_mode;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            conv_cnt <= '0;
        else
            conv_cnt <= in_convert ? conv_cnt + CW'(1) : '0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            test_cnt <= '0;
        else
            test_cnt <= in_test ? test_cnt + TW'(1) : '0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            half_cnt <= '0;
        else
            half_cnt <= (in_data & ~half_end) ? half_cnt + HW'(1) : '0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sck_level <= 1'b1;
            rise_cnt  <= 5'h0;
        end
        else
        begin
            sck_level <= next_level;
            rise_cnt  <= next_rise;
        end
    end

    // The result is frozen when the status falls and stays static
    // through sleep, which lets the link domain read it directly.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            result_word <= '0;
        else if (conv_end)
            result_word <= {1'b0, adc_result};
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_word   <= '0;
            config_update <= 1'b0;
        end
        else
        begin
            config_update <= cfg_evt;
            if (cfg_evt)
                config_word <= link_cfg;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converting       <= 1'b1;
            pullup_force     <= 1'b0;
            serial_clock_oe  <= 1'b0;
            serial_clock_out <= 1'b1;
        end
        else
        begin
            converting       <= (next_state == ast_pkg::ST_CONVERT);
            pullup_force     <= next_force;
            serial_clock_oe  <= ~next_ext_mode & ~cs_s;
            serial_clock_out <= next_level;
        end
    end

    // Link counters and shift state are held clear while select is high or a conversion
    // runs. Release happens in sleep, or on entry to the status window, when the clock pin is idle.
    wire link_rst_n = reset_n & ~chip_select_n & ~converting;

    ast_link #(
        .CFG_BITS (CFG_BITS)
    ) u_link (
        .sck        (serial_clock_in),
        .reset_n    (reset_n),
        .link_rst_n (link_rst_n),
        .config_in  (serial_config_in),
        .word       (result_word),
        .out_bit    (link_bit),
        .rise_tgl   (rise_tgl),
        .done_tgl   (done_tgl),
        .cfg_tgl    (cfg_tgl),
        .cfg_word   (link_cfg)
    );

    // While converting the pin shows a one; asleep it shows the link
    // bit, which is the zero status bit until the first fall after a rise.
    assign serial_result_out      = converting | link_bit;
    assign serial_result_oe       = ~chip_select_n;
    assign serial_clock_pullup_en = sck_s | pullup_force;

    a_sleep_after_conv: assert property (@(posedge clock) disable iff (!reset_n)
        conv_end |=> (in_sleep | in_test))
        else $error("conversion end did not leave convert state");

    a_result_load: assert property (@(posedge clock) disable iff (!reset_n)
        conv_end |=> (result_word[ast_pkg::WORD_BITS-2:0] == $past(adc_result)))
        else $error("result not loaded at conversion end");

    a_sleep_holds: assert property (@(posedge clock) disable iff (!reset_n)
        (in_sleep & ext_clock_mode & ~rise_evt & ~cs_fall) |=> in_sleep)
        else $error("left sleep without a rising clock");

    a_ext_done_conv: assert property (@(posedge clock) disable iff (!reset_n)
        (in_data & ext_clock_mode & done_evt) |=> (in_convert ##1 converting))
        else $error("24th falling edge did not start conversion");

    a_abort_conv: assert property (@(posedge clock) disable iff (!reset_n)
        (in_data & cs_rise) |=> in_convert)
        else $error("select rise did not abort data output");

    a_mode_sample: assert property (@(posedge clock) disable iff (!reset_n)
        cs_fall |=> (ext_clock_mode == ~$past(sck_s)))
        else $error("mode not taken from clock level");

    a_test_window: assert property (@(posedge clock) disable iff (!reset_n)
        (in_test & ~cs_rise & (test_cnt != TEST_LAST)) |=> in_test)
        else $error("status window ended early");

    a_poll_sleep: assert property (@(posedge clock) disable iff (!reset_n)
        (in_test & cs_rise) |=> (in_sleep & pullup_force))
        else $error("early select rise did not return to sleep");

    a_int_finish: assert property (@(posedge clock) disable iff (!reset_n)
        int_last |=> (in_convert & sck_level) ##1 serial_clock_out)
        else $error("internal clock not high after 24th rise");

    a_int_abort: assert property (@(posedge clock) disable iff (!reset_n)
        (in_data & ~ext_clock_mode & cs_rise) |=> (in_convert & sck_level))
        else $error("internal data cycle not aborted");

    a_pullup_low: assert property (@(posedge clock) disable iff (!reset_n)
        (~sck_s & ~pullup_force) |-> ~serial_clock_pullup_en)
        else $error("pull-up active while clock low");

endmodule

`default_nettype wire
